// *** cpm_defs.svh ***
// Constants for the CAN power mode and bit timing block.
// Assumes inclusion by bare name from the design module.
`ifndef CPM_DEFS_SVH
`define CPM_DEFS_SVH
// Register offsets on the plain register port
`define CPM_A_CTRL0 8'h00
`define CPM_A_CTRL1 8'h01
`define CPM_A_TIM0 8'h02
`define CPM_A_TIM1 8'h03
`define CPM_A_STAT 8'h04
// Bit positions in module_control_zero
`define CPM_B_SLP 0
`define CPM_B_SRST 1
`define CPM_B_ACK 2
`define CPM_B_LINK 3
// Bit positions in module_control_one
`define CPM_B_CSEL 0
`define CPM_B_WFLT 1
// Fields of bus_timing_zero and bus_timing_one
`define CPM_F_PRE 5:0
`define CPM_F_SJW 7:6
`define CPM_F_TS1 3:0
`define CPM_F_TS2 6:4
// Reset values
`define CPM_RST_SRST 1'b1
`define CPM_RST_TIM0 8'h00
`define CPM_RST_TIM1 7'h00
// Bit timing limits and counts
`define CPM_SEG1_MIN 5'h04
`define CPM_SEG2_MIN 5'h02
`define CPM_REC_BITS 4'hB
`endif

// *** cpm_pkg.sv ***
// Types for the CAN power mode and bit timing block.
// Assumes nothing beyond a SystemVerilog compiler.
package cpm_pkg;
    // Controller operating mode, one-hot
    typedef enum logic [5:0] {
        CPM_RUN = 6'h01,
        CPM_DRAIN = 6'h02,
        CPM_SLEEP = 6'h04,
        CPM_RESYNC = 6'h08,
        CPM_SOFTRST = 6'h10,
        CPM_PDOWN = 6'h20
    } cpm_state_type;
endpackage : cpm_pkg

// *** cpm_top.sv ***
// Power modes, wake-up, timestamp link and bit timing of a CAN controller.
// Assumes one 100 MHz clock; engine status inputs are on this clock.
`timescale 1ns/1ps
`include "cpm_defs.svh"
`default_nettype none

module cpm_top import cpm_pkg::*; #(
    parameter int FILT_CYC = 16 // Dominant cycles for a filtered wake
) (
    input wire logic clk, // 100 MHz clock
    input wire logic resetn, // Async reset, active low
    input wire logic [7:0] addr, // Register address
    input wire logic [7:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [7:0] rdata, // Read data, cycle after rd
    input wire logic bus_rx_pin, // Bus receive line, async
    output logic bus_tx_pin, // Bus transmit line
    input wire logic eng_tx, // Transmit bit from protocol engine
    input wire logic tx_busy, // Engine has scheduled or active transmit
    input wire logic rx_busy, // Engine is receiving a frame
    input wire logic frame_ok, // Valid frame end pulse from engine
    input wire logic bus_off, // Engine is bus-off
    input wire logic cpu_stop, // CPU in stop mode
    input wire logic cpu_wait, // CPU in wait mode
    input wire logic [2:0] irq_in, // Enabled tx, rx, error interrupts
    output logic sleep_acknowledge, // Controller asleep
    output logic engine_run, // Engine may take part on bus
    output logic engine_halt, // Engine held stopped
    output logic copy_en, // Receive buffer copy allowed
    output logic abort_en, // Message aborts allowed
    output logic boff_count_en, // Bus-off recovery count runs
    output logic controller_clock_select, // 0 crystal, 1 PLL
    output logic tq_tick, // Time quantum pulse
    output logic sample_tick, // Sample point pulse
    output logic bit_tick, // Bit boundary pulse
    output logic rx_bit, // Last sampled bus bit
    output logic timer_capture, // Timestamp to timer channel
    output logic mcu_wakeup, // Wake request to processor
    output logic wait_exit // Ends CPU wait
);

    // Filter counter is eight bits wide
    if (FILT_CYC < 1 || FILT_CYC > 256) begin : g_chk
        $error("FILT_CYC out of range");
    end

    localparam logic [7:0] FILT_MAX = 8'(FILT_CYC - 1); // Last filter count

    // Segment length from a minus-one field, clamped to its minimum
    function automatic logic [4:0] seg_len(input logic [3:0] f, input logic [4:0] mn);
        logic [4:0] l;
        l = {1'b0, f} + 5'h01;
        return (l < mn) ? mn : l;
    endfunction : seg_len

    // Smaller of a value and the jump width
    function automatic logic [2:0] clip(input logic [5:0] v, input logic [2:0] lim);
        return (v < {3'h0, lim}) ? v[2:0] : lim;
    endfunction : clip

    cpm_state_type state_r; // Operating mode
    cpm_state_type state_nxt; // Next mode
    cpm_state_type step; // Mode from normal sequencing
    logic slp_r; // sleep_request
    logic srst_r; // soft_reset_request
    logic link_r; // timestamp_link_enable
    logic wflt_r; // wakeup_filter_select
    logic [7:0] tim0_r; // bus_timing_zero
    logic [6:0] tim1_r; // bus_timing_one
    logic rx_m_r; // Synchroniser first stage
    logic rx_s_r; // Synchronised bus level
    logic rx_d_r; // Delayed level for edges
    logic [5:0] pre_r; // Prescaler count
    logic [4:0] q_r; // Quantum index in bit
    logic [2:0] ext_r; // Seg1 lengthening
    logic [2:0] shr_r; // Seg2 shortening
    logic sync_done_r; // Resync used this bit
    logic [3:0] rec_r; // Recessive bit count
    logic [7:0] filt_r; // Dominant cycle count
    logic ts_pend_r; // Frame end awaiting bit edge
    logic ts_on_r; // Timestamp pulse active

    // Mode decode
    wire is_sleep = (state_r == CPM_SLEEP);
    wire is_resync = (state_r == CPM_RESYNC);
    wire is_pdown = (state_r == CPM_PDOWN);
    wire run_nxt = (state_nxt == CPM_RUN) || (state_nxt == CPM_DRAIN);
    wire halt_nxt = (state_nxt == CPM_SOFTRST) || (state_nxt == CPM_PDOWN);
    wire sleep_nxt = (state_nxt == CPM_SLEEP);

    wire acc_ok = !cpu_stop && !is_pdown;
    wire w0 = wr && acc_ok && (addr == `CPM_A_CTRL0);
    wire w1 = wr && acc_ok && (addr == `CPM_A_CTRL1);
    wire w2 = wr && acc_ok && (addr == `CPM_A_TIM0);
    wire w3 = wr && acc_ok && (addr == `CPM_A_TIM1);

    wire dom = !rx_s_r;
    wire filt_hit = (filt_r == FILT_MAX) && dom;
    wire wake_bus = is_sleep && (wflt_r ? filt_hit : dom);
    wire [7:0] filt_nxt = (is_sleep && dom && !filt_hit) ? filt_r + 8'h01 : 8'h00;

    wire slp_nxt = w0 ? (wdata[`CPM_B_SLP] || (slp_r && !is_sleep))
                      : (wake_bus ? 1'b0 : slp_r);

    wire [4:0] t1 = seg_len(tim1_r[`CPM_F_TS1], `CPM_SEG1_MIN);
    wire [4:0] t2 = seg_len({1'b0, tim1_r[`CPM_F_TS2]}, `CPM_SEG2_MIN);
    wire [2:0] resync_jump_width = {1'b0, tim0_r[`CPM_F_SJW]} + 3'h1;
    wire [5:0] bend = {1'b0, t1} + {1'b0, t2} + {3'h0, ext_r} - {3'h0, shr_r};
    wire [5:0] samp = {1'b0, t1} + {3'h0, ext_r};
    wire [5:0] q6 = {1'b0, q_r};

    // timing stops in sleep and halts
    wire tim_on = (state_r == CPM_RUN) || (state_r == CPM_DRAIN) || is_resync;
    wire pre_hit = (pre_r == tim0_r[`CPM_F_PRE]);
    wire tq = tim_on && pre_hit;
    wire bit_end = tq && (q6 >= bend);
    wire samp_hit = tq && (q6 == samp);
    wire [5:0] pre_nxt = (!tim_on || pre_hit) ? 6'h00 : pre_r + 6'h01;
    wire [4:0] q_nxt = (!tim_on || bit_end) ? 5'h00 : (tq ? q_r + 5'h01 : q_r);

    // Resync on a falling edge outside the edge_expected_slot
    wire edge_ok = rx_d_r && !rx_s_r && tim_on && !sync_done_r && (q_r != 5'h00);
    wire in_seg1 = (q6 <= samp);
    wire [2:0] ext_nxt = bit_end ? 3'h0 : ((edge_ok && in_seg1) ? clip(q6, resync_jump_width) : ext_r);
    wire [2:0] shr_nxt = bit_end ? 3'h0
                       : ((edge_ok && !in_seg1) ? clip(bend - q6, resync_jump_width) : shr_r);
    wire sync_nxt = bit_end ? 1'b0 : (edge_ok ? 1'b1 : sync_done_r);

    // count recessive sample points after wake
    wire rec_done = (rec_r == `CPM_REC_BITS);
    wire [3:0] rec_nxt = !is_resync ? 4'h0
                       : (samp_hit ? (rx_s_r ? (rec_done ? rec_r : rec_r + 4'h1) : 4'h0)
                                   : rec_r);

    // pulse spans one bit after frame end
    wire ts_pend_nxt = frame_ok ? 1'b1 : (bit_end ? 1'b0 : ts_pend_r);
    wire ts_on_nxt = bit_end ? ts_pend_r : ts_on_r;

    // Register read selection
    wire [7:0] rd_val = (addr == `CPM_A_CTRL0) ?
                            {4'h0, link_r, sleep_acknowledge, srst_r, slp_r} :
                        (addr == `CPM_A_CTRL1) ? {6'h00, wflt_r, controller_clock_select} :
                        (addr == `CPM_A_TIM0) ? tim0_r :
                        (addr == `CPM_A_TIM1) ? {1'b0, tim1_r} :
                        (addr == `CPM_A_STAT) ? {2'h0, state_r} : 8'h00;

    // Mode sequencing
    always_comb begin
        step = state_r;
        case (state_r)
            CPM_RUN: begin
                if (slp_r && (tx_busy || rx_busy)) begin
                    step = CPM_DRAIN;
                end else if (slp_r) begin
                    step = CPM_SLEEP;
                end
            end
            CPM_DRAIN: begin
                // sleep once transmit and receive end
                if (!tx_busy && !rx_busy) begin
                    step = CPM_SLEEP;
                end
            end
            CPM_SLEEP: begin
                // wake on bus or request clear
                if (wake_bus || !slp_r) begin
                    step = CPM_RESYNC;
                end
            end
            CPM_RESYNC: begin
                if (rec_done) begin
                    step = CPM_RUN;
                end
            end
            CPM_SOFTRST: begin
                // Leaving soft reset resynchronises
                if (!srst_r) begin
                    step = CPM_RESYNC;
                end
            end
            CPM_PDOWN: begin
                if (!cpu_stop) begin
                    step = CPM_RESYNC;
                end
            end
            default: begin
                step = CPM_SOFTRST;
            end
        endcase
    end

    assign state_nxt = cpu_stop ? CPM_PDOWN : (srst_r ? CPM_SOFTRST : step);

    // Mode and control registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= CPM_SOFTRST;
            slp_r <= 1'b0;
            srst_r <= `CPM_RST_SRST;
            link_r <= 1'b0;
            wflt_r <= 1'b0;
            controller_clock_select <= 1'b0;
            tim0_r <= `CPM_RST_TIM0;
            tim1_r <= `CPM_RST_TIM1;
        end else begin
            state_r <= state_nxt;
            slp_r <= slp_nxt;
            // registers stay writable in soft reset
            srst_r <= w0 ? wdata[`CPM_B_SRST] : srst_r;
            link_r <= w0 ? wdata[`CPM_B_LINK] : link_r;
            wflt_r <= w1 ? wdata[`CPM_B_WFLT] : wflt_r;
            controller_clock_select <= w1 ? wdata[`CPM_B_CSEL] : controller_clock_select;
            tim0_r <= w2 ? wdata : tim0_r;
            tim1_r <= w3 ? wdata[6:0] : tim1_r;
        end
    end

    // Synchroniser and bit timing state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_m_r <= 1'b1;
            rx_s_r <= 1'b1;
            rx_d_r <= 1'b1;
            pre_r <= 6'h00;
            q_r <= 5'h00;
            ext_r <= 3'h0;
            shr_r <= 3'h0;
            sync_done_r <= 1'b0;
            rec_r <= 4'h0;
            filt_r <= 8'h00;
            ts_pend_r <= 1'b0;
            ts_on_r <= 1'b0;
        end else begin
            rx_m_r <= bus_rx_pin;
            rx_s_r <= rx_m_r;
            rx_d_r <= rx_s_r;
            pre_r <= pre_nxt;
            q_r <= q_nxt;
            ext_r <= ext_nxt;
            shr_r <= shr_nxt;
            sync_done_r <= sync_nxt;
            rec_r <= rec_nxt;
            filt_r <= filt_nxt;
            ts_pend_r <= ts_pend_nxt;
            ts_on_r <= ts_on_nxt;
        end
    end

    // Registered outputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 8'h00;
            bus_tx_pin <= 1'b1;
            sleep_acknowledge <= 1'b0;
            engine_run <= 1'b0;
            engine_halt <= 1'b1;
            copy_en <= 1'b0;
            abort_en <= 1'b0;
            boff_count_en <= 1'b0;
            tq_tick <= 1'b0;
            sample_tick <= 1'b0;
            bit_tick <= 1'b0;
            rx_bit <= 1'b1;
            timer_capture <= 1'b0;
            mcu_wakeup <= 1'b0;
            wait_exit <= 1'b0;
        end else begin
            rdata <= (rd && acc_ok) ? rd_val : 8'h00;
            bus_tx_pin <= run_nxt ? eng_tx : 1'b1;
            sleep_acknowledge <= sleep_nxt;
            engine_run <= run_nxt;
            engine_halt <= halt_nxt;
            copy_en <= !sleep_nxt && !halt_nxt;
            abort_en <= !sleep_nxt && !halt_nxt;
            boff_count_en <= bus_off && run_nxt;
            tq_tick <= tq;
            sample_tick <= samp_hit;
            bit_tick <= bit_end;
            rx_bit <= samp_hit ? rx_s_r : rx_bit;
            timer_capture <= ts_on_nxt && link_r;
            mcu_wakeup <= is_pdown && dom;
            // wait mode does not gate engine
            wait_exit <= cpu_wait && (|irq_in);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence idle_req_s;
        (state_r == CPM_RUN) && slp_r && !tx_busy && !rx_busy && !srst_r && !cpu_stop;
    endsequence
    sequence drain_busy_s;
        (state_r == CPM_DRAIN) && tx_busy && !srst_r && !cpu_stop;
    endsequence

    sleep_at_once_a: assert property (idle_req_s |=> is_sleep ##0 sleep_acknowledge)
        else $error("idle sleep request not taken");
    drain_hold_a: assert property (drain_busy_s |=> !is_sleep)
        else $error("slept with transmit pending");
    rx_drain_a: assert property ((state_r == CPM_DRAIN) && rx_busy |=> !is_sleep)
        else $error("slept during reception");
    ack_track_a: assert property (sleep_acknowledge == is_sleep)
        else $error("acknowledge differs from sleep");
    tx_recess_a: assert property (is_sleep || is_pdown |-> bus_tx_pin)
        else $error("transmit not recessive in low power");
    sleep_defer_a: assert property (is_sleep |-> !copy_en && !abort_en && !boff_count_en)
        else $error("action taken while asleep");
    clear_hold_a: assert property (w0 && !wdata[`CPM_B_SLP] && !is_sleep && slp_r
                                   |=> slp_r)
        else $error("request cleared before acknowledge");
    srst_halt_a: assert property (srst_r && !cpu_stop |=> engine_halt && !engine_run)
        else $error("soft reset did not halt");
    stop_block_a: assert property (cpu_stop && rd |=> rdata == 8'h00)
        else $error("read answered in stop");
    resync_wait_a: assert property (is_resync && !rec_done && !cpu_stop && !srst_r
                                    |=> !engine_run)
        else $error("joined bus before recessive run");
    link_gate_a: assert property (timer_capture |-> $past(link_r) && $past(ts_on_nxt))
        else $error("timestamp passed while unlinked");
    tq_space_a: assert property (tq_tick && tim0_r[`CPM_F_PRE] != 6'h00
                                 |=> !tq_tick)
        else $error("quantum pulses too close");

endmodule : cpm_top

`default_nettype wire

// *** cpm_bus_node.sv ***
// Far side of the block: the other nodes on the bus, seen through a transceiver.
// Assumes the testbench asks for dominant levels; the line idles recessive.
`timescale 1ns/1ps
`default_nettype none

module cpm_bus_node (
    input wire logic bus_tx_pin, // Our node's transmit line
    input wire logic dom_req, // Another node drives dominant
    output logic bus_rx_pin // Resulting bus level, 1 recessive
);
    // Wired-AND bus: any dominant driver wins, pulled recessive otherwise
    assign bus_rx_pin = bus_tx_pin & ~dom_req;
endmodule : cpm_bus_node
`default_nettype wire

// *** tb_cpm_top.sv ***
// Self-checking testbench for the CAN power mode and bit timing block.
// Assumes the bus node model and one 100 MHz clock.
`timescale 1ns/1ps
`include "cpm_defs.svh"
`default_nettype none

module tb_cpm_top import cpm_pkg::*;;
    logic clk = 1'b0; // Clock, driven only by its own process
    logic resetn, wr, rd, eng_tx, tx_busy, rx_busy, frame_ok; // Stimulus
    logic bus_off, cpu_stop, cpu_wait, dom; // Mode and bus stimulus
    logic [7:0] addr, wdata, rdata, rv; // Register port
    logic [2:0] irq_in; // Interrupt levels
    logic bus_rx_pin, bus_tx_pin, ack, erun, halt, copy_en, abort_en, boff; // Outputs
    logic csel, tcap, mwake, wexit, bit_tick, tqt, smp, rxb; // Outputs
    int failures, checks_done, cyc, n; // Counters

    cpm_bus_node node_u (.bus_tx_pin(bus_tx_pin), .dom_req(dom), .bus_rx_pin(bus_rx_pin));
    cpm_top #(.FILT_CYC(4)) dut_u (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .bus_rx_pin(bus_rx_pin), .bus_tx_pin(bus_tx_pin),
        .eng_tx(eng_tx), .tx_busy(tx_busy), .rx_busy(rx_busy), .frame_ok(frame_ok),
        .bus_off(bus_off), .cpu_stop(cpu_stop), .cpu_wait(cpu_wait), .irq_in(irq_in),
        .sleep_acknowledge(ack), .engine_run(erun), .engine_halt(halt), .copy_en(copy_en),
        .abort_en(abort_en), .boff_count_en(boff), .controller_clock_select(csel),
        .tq_tick(tqt), .sample_tick(smp), .bit_tick(bit_tick), .rx_bit(rxb),
        .timer_capture(tcap),
        .mcu_wakeup(mwake), .wait_exit(wexit));

    // Clock, 10 ns period
    always #5 clk = ~clk;

    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One write cycle
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // One read cycle, data taken in the following cycle
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    task automatic ticks(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : ticks

    // Poll the status register until it shows the given state
    task automatic wait_st(input logic [7:0] exp);
        int k;
        k = 0;
        rd_reg(`CPM_A_STAT, rv);
        while (rv !== exp && k < 150) begin
            rd_reg(`CPM_A_STAT, rv);
            k++;
        end
        chk(rv, exp);
    endtask : wait_st

    // Clocks, quanta and sample point offset between two bit boundaries
    task automatic bit_len(output int len, output int nq, output int sp);
        int k;
        k = 0;
        len = 0;
        nq = 0;
        sp = 0;
        while (k < 300 && (k == 0 || bit_tick !== 1'b1)) begin
            ticks(1);
            k++;
        end
        while (len < 300 && (len == 0 || bit_tick !== 1'b1)) begin
            ticks(1);
            len++;
            // Quanta ending inside this bit
            if (tqt === 1'b1) begin
                nq++;
            end
            // Clocks from bit start to the sample point
            if (smp === 1'b1) begin
                sp = len;
            end
        end
    endtask : bit_len

    // Reset values, unmapped read, timing boundaries, release
    task automatic t_reset_timing;
        logic [7:0] t0 [3] = '{8'h01, 8'h00, 8'h00};
        logic [7:0] t1 [3] = '{8'h24, 8'h7F, 8'h31};
        // Clocks, quanta, sample offset per setting; seg1 field 1 clamps to four
        logic [7:0] bl [3] = '{8'h12, 8'h19, 8'h09};
        logic [7:0] bq [3] = '{8'h09, 8'h19, 8'h09};
        logic [7:0] bs [3] = '{8'h0C, 8'h11, 8'h05};
        int q, s;
        rd_reg(`CPM_A_STAT, rv);
        chk(rv, {2'h0, CPM_SOFTRST});
        rd_reg(`CPM_A_CTRL0, rv);
        chk(rv, 8'h02);
        rd_reg(8'h07, rv);
        chk(rv, 8'h00);
        chk({halt, bus_tx_pin}, 8'h03);
        for (int i = 0; i < 3; i++) begin
            wr_reg(`CPM_A_CTRL0, 8'h02);
            wr_reg(`CPM_A_TIM0, t0[i]);
            wr_reg(`CPM_A_TIM1, t1[i]);
            rd_reg(`CPM_A_TIM1, rv);
            chk(rv, t1[i]);
            wr_reg(`CPM_A_CTRL0, 8'h00);
            bit_len(n, q, s);
            chk(8'(n), bl[i]);
            chk(8'(q), bq[i]);
            chk(8'(s), bs[i]);
        end
        wait_st({2'h0, CPM_RUN});
    endtask : t_reset_timing

    // Idle sleep, recessive pin, stopped copies and recovery count
    task automatic t_idle_sleep;
        bus_off <= 1'b1;
        wr_reg(`CPM_A_CTRL0, 8'h01);
        ticks(2);
        chk({ack, copy_en, abort_en, boff}, 8'h08);
        eng_tx <= 1'b0;
        ticks(3);
        chk(bus_tx_pin, 8'h01);
        eng_tx <= 1'b1;
        wr_reg(`CPM_A_CTRL0, 8'h00);
        ticks(2);
        chk(ack, 8'h00);
        wait_st({2'h0, CPM_RUN});
        chk({copy_en, abort_en, boff}, 8'h07);
        bus_off <= 1'b0;
    endtask : t_idle_sleep

    // Busy transmit then busy receive: drain first, early clear refused
    task automatic t_drain;
        for (int i = 0; i < 2; i++) begin
            tx_busy <= (i == 0);
            rx_busy <= (i == 1);
            wr_reg(`CPM_A_CTRL0, 8'h01);
            wait_st({2'h0, CPM_DRAIN});
            chk(erun, 8'h01);
            wr_reg(`CPM_A_CTRL0, 8'h00);
            rd_reg(`CPM_A_CTRL0, rv);
            chk(rv, 8'h01);
            tx_busy <= 1'b0;
            rx_busy <= 1'b0;
            ticks(3);
            chk(ack, 8'h01);
            wr_reg(`CPM_A_CTRL0, 8'h00);
            wait_st({2'h0, CPM_RUN});
        end
    endtask : t_drain

    // Wake by bus activity, with and without the glitch filter
    task automatic t_bus_wake;
        for (int f = 1; f >= 0; f--) begin
            wr_reg(`CPM_A_CTRL1, f ? 8'h02 : 8'h00);
            wr_reg(`CPM_A_CTRL0, 8'h01);
            ticks(2);
            if (f == 1) begin
                dom <= 1'b1;
                ticks(2);
                dom <= 1'b0;
                ticks(8);
                chk(ack, 8'h01);
            end
            dom <= 1'b1;
            ticks(20);
            chk(ack, 8'h00);
            chk(rxb, 8'h00);
            rd_reg(`CPM_A_STAT, rv);
            chk(rv, {2'h0, CPM_RESYNC});
            rd_reg(`CPM_A_CTRL0, rv);
            chk(rv, 8'h00);
            dom <= 1'b0;
            wait_st({2'h0, CPM_RUN});
            chk(rxb, 8'h01);
        end
    endtask : t_bus_wake

    // Soft reset wakes a sleeper and halts a busy controller at once
    task automatic t_soft_reset;
        wr_reg(`CPM_A_CTRL0, 8'h01);
        ticks(2);
        wr_reg(`CPM_A_CTRL0, 8'h03);
        wait_st({2'h0, CPM_SOFTRST});
        rd_reg(`CPM_A_CTRL0, rv);
        chk(rv, 8'h03);
        wr_reg(`CPM_A_CTRL0, 8'h00);
        wait_st({2'h0, CPM_SLEEP});
        wr_reg(`CPM_A_CTRL0, 8'h00);
        wait_st({2'h0, CPM_RUN});
        tx_busy <= 1'b1;
        eng_tx <= 1'b0;
        wr_reg(`CPM_A_CTRL0, 8'h02);
        ticks(2);
        chk({halt, erun, bus_tx_pin}, 8'h05);
        rd_reg(`CPM_A_TIM1, rv);
        chk(rv, 8'h31);
        eng_tx <= 1'b1;
        tx_busy <= 1'b0;
        wr_reg(`CPM_A_CTRL0, 8'h00);
        wait_st({2'h0, CPM_RUN});
    endtask : t_soft_reset

    // Stop mode: halt, recessive pin, registers shut, bus wakes processor
    task automatic t_stop;
        cpu_stop <= 1'b1;
        eng_tx <= 1'b0;
        ticks(3);
        chk({halt, bus_tx_pin}, 8'h03);
        rd_reg(`CPM_A_STAT, rv);
        chk(rv, 8'h00);
        wr_reg(`CPM_A_CTRL0, 8'h02);
        dom <= 1'b1;
        ticks(5);
        chk(mwake, 8'h01);
        dom <= 1'b0;
        cpu_stop <= 1'b0;
        eng_tx <= 1'b1;
        wait_st({2'h0, CPM_RUN});
    endtask : t_stop

    // Wait mode: still active, each enabled interrupt ends the wait
    task automatic t_wait;
        cpu_wait <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            irq_in <= 3'(1 << i);
            ticks(3);
            chk({wexit, erun}, 8'h03);
            irq_in <= 3'h0;
            ticks(3);
            chk(wexit, 8'h00);
        end
        cpu_wait <= 1'b0;
    endtask : t_wait

    // Timestamp reaches the timer only when linked, one bit long
    task automatic t_stamp_clk;
        for (int l = 0; l < 2; l++) begin
            wr_reg(`CPM_A_CTRL0, l ? 8'h08 : 8'h00);
            @(posedge clk);
            frame_ok <= 1'b1;
            @(posedge clk);
            frame_ok <= 1'b0;
            n = 0;
            while (tcap !== 1'b1 && n < 40) begin
                ticks(1);
                n++;
            end
            n = 0;
            while (tcap === 1'b1 && n < 40) begin
                ticks(1);
                n++;
            end
            chk(8'(n), l ? 8'h09 : 8'h00);
        end
        wr_reg(`CPM_A_CTRL1, 8'h01);
        ticks(1);
        chk(csel, 8'h01);
        wr_reg(`CPM_A_CTRL1, 8'h00);
        ticks(1);
        chk(csel, 8'h00);
    endtask : t_stamp_clk

    // Report and end the run
    task automatic finish_test;
        $display("Checks done %0d, failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    // Cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            finish_test();
        end
    end

    // Main sequence
    initial begin
        {resetn, wr, rd, tx_busy, rx_busy, frame_ok, bus_off} = '0;
        {cpu_stop, cpu_wait, dom, addr, wdata, irq_in} = '0;
        eng_tx = 1'b1;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        t_reset_timing();
        t_idle_sleep();
        t_drain();
        t_bus_wake();
        t_soft_reset();
        t_stop();
        t_wait();
        t_stamp_clk();
        finish_test();
    end
endmodule : tb_cpm_top
`default_nettype wire
